// ### rtl/fpwdl_pkg.sv
// Notes on behaviour
// RULE_01: software polls the write-busy flag and starts a posted write only at zero
// RULE_02: software writes unlock key, then page, halfword address, and data last
// RULE_03: writing the data field posts the flash write; the bus never stalls
// RULE_04: write-busy flag stays set while the posted write runs, clears when done
// RULE_05: lock pattern then 0x6969 to debug access register blows the fuse
// RULE_06: once blown, every debug port read and write is refused for good
// RULE_07: debug blocking starts right after the second protection write
// RULE_08: a data write without a preceding unlock key starts nothing
// RULE_09: each posted write carries one 16-bit halfword
// RULE_10: byte address is page times 1024 plus twice the halfword field
// RULE_11: a direct flash write stalls the bus until programming completes
package fpwdl_pkg;

  // register byte offsets
  localparam logic [7:0] FPWDL_CTL_OFS     = 8'h00;
  localparam logic [7:0] FPWDL_KEY_OFS     = 8'h04;
  localparam logic [7:0] FPWDL_PAYLOAD_OFS = 8'h08;
  localparam logic [7:0] FPWDL_UNLOCK_OFS  = 8'h0C;
  localparam logic [7:0] FPWDL_DBGACC_OFS  = 8'h10;
  localparam logic [7:0] FPWDL_WSTATE_OFS  = 8'h14;
  localparam logic [7:0] FPWDL_DIRECT_OFS  = 8'h18;

  // control register bits
  localparam int FPWDL_CTL_BUSY_BIT   = 0;
  localparam int FPWDL_CTL_FUSE_BIT   = 1;
  localparam int FPWDL_CTL_ARMED_BIT  = 2;

  // payload and direct-write field layout
  localparam int FPWDL_DATA_LSB = 0;
  localparam int FPWDL_DATA_W   = 16;
  localparam int FPWDL_HW_LSB   = 16;
  localparam int FPWDL_HW_W     = 9;
  localparam int FPWDL_PAGE_LSB = 25;
  localparam int FPWDL_PAGE_W   = 5;
  localparam int FPWDL_ADDR_W   = 15;
  localparam int FPWDL_WS_W     = 2;

  // patterns and reset values
  localparam logic [31:0] FPWDL_LOCK_PATTERN  = 32'hF98362AB;
  localparam logic [15:0] FPWDL_BLOW_PATTERN  = 16'h6969;
  // arbitrary value
  localparam logic [31:0] FPWDL_UNLOCK_KEY    = 32'h0000A5C3;
  localparam logic [1:0]  FPWDL_WSTATE_RESET  = 2'h3;

  typedef struct packed {
    logic [FPWDL_ADDR_W-1:0] addr;
    logic [FPWDL_DATA_W-1:0] data;
  } fpwdl_cmd_s;

endpackage : fpwdl_pkg

// ### rtl/fpwdl_prog.sv
`timescale 1ns/1ps
module fpwdl_prog
  import fpwdl_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // command side
  input  wire logic       start,
  input  wire fpwdl_cmd_s cmd,
  output logic            busy,
  output logic            done,
  // flash array side
  output logic            flash_req,
  output fpwdl_cmd_s      flash_cmd,
  input  wire logic       flash_ack
);

  typedef struct packed {
    logic       busy;
    logic       done;
    fpwdl_cmd_s cmd;
  } fpwdl_prog_s;

  fpwdl_prog_s st;
  fpwdl_prog_s next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (st.busy && flash_ack) begin
      next_st.busy = 1'b0; // see RULE_04
      next_st.done = 1'b1;
    end else if (!st.busy && start) begin
      next_st.busy = 1'b1;
      next_st.cmd  = cmd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy      = st.busy;
  assign done      = st.done;
  assign flash_req = st.busy;
  assign flash_cmd = st.cmd;

endmodule : fpwdl_prog

// ### rtl/fpwdl_fuse.sv
`timescale 1ns/1ps
module fpwdl_fuse
  import fpwdl_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // protection writes, decoded by the register file
  input  wire logic lock_write,
  input  wire logic lock_match,
  input  wire logic blow_write,
  input  wire logic blow_match,
  input  wire logic other_write,
  // fuse cell
  input  wire logic fuse_sense,
  output logic      fuse_blow,
  // debug port gate
  input  wire logic dbg_req,
  output logic      dbg_grant,
  output logic      dbg_refused,
  output logic      blocked,
  output logic      armed
);

  typedef struct packed {
    logic armed;
    logic burnt;
    logic blow;
  } fpwdl_fuse_s;

  fpwdl_fuse_s st;
  fpwdl_fuse_s next_st;

  always_comb begin
    next_st      = st;
    next_st.blow = 1'b0;
    if (lock_write) begin
      next_st.armed = lock_match;
    end else if (blow_write) begin
      next_st.armed = 1'b0;
      if (st.armed && blow_match) begin
        next_st.burnt = 1'b1; // see RULE_05
        next_st.blow  = 1'b1;
      end
    end else if (other_write) begin
      next_st.armed = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // cell survives reset; local latch covers the cycles until it senses
  assign blocked     = st.burnt | fuse_sense; // see RULE_06 see RULE_07
  assign dbg_grant   = dbg_req & ~blocked;    // see RULE_06
  assign dbg_refused = dbg_req & blocked;
  assign fuse_blow   = st.blow;
  assign armed       = st.armed;

endmodule : fpwdl_fuse

// ### rtl/fpwdl_top.sv
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module fpwdl_top
  import fpwdl_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flash array
  output logic             flash_req,
  output fpwdl_cmd_s       flash_cmd,
  input  wire logic        flash_ack,
  output logic [1:0]       flash_wait_states,
  // protection fuse cell
  input  wire logic        fuse_sense,
  output logic             fuse_blow,
  // debug port gate
  input  wire logic        dbg_req,
  output logic             dbg_grant,
  output logic             dbg_refused,
  output logic             dbg_locked
);

  typedef struct packed {
    logic                    key_ok;
    logic                    direct_run;
    logic [FPWDL_WS_W-1:0]   wstate;
    logic [FPWDL_PAGE_W-1:0] page;
    logic [FPWDL_HW_W-1:0]   hw;
    logic [FPWDL_DATA_W-1:0] data;
    logic [31:0]             rdata;
    logic                    slverr;
  } fpwdl_top_s;

  fpwdl_top_s st;
  fpwdl_top_s next_st;

  logic       setup;
  logic       access;
  logic       wr_access;
  logic       mapped;
  logic       prog_busy;
  logic       prog_done;
  logic       prog_start;
  fpwdl_cmd_s prog_cmd;
  logic       fuse_blocked;
  logic       hit_ctl;
  logic       hit_key;
  logic       hit_payload;
  logic       hit_unlock;
  logic       hit_dbgacc;
  logic       hit_wstate;
  logic       hit_direct;
  logic       direct_hold;
  logic       lock_write;
  logic       blow_write;
  logic       blow_match;
  logic       other_write;
  logic       data_lane;

  assign setup  = psel & ~penable;
  assign access = psel & penable;

  assign hit_ctl     = (paddr == FPWDL_CTL_OFS);
  assign hit_key     = (paddr == FPWDL_KEY_OFS);
  assign hit_payload = (paddr == FPWDL_PAYLOAD_OFS);
  assign hit_unlock  = (paddr == FPWDL_UNLOCK_OFS);
  assign hit_dbgacc  = (paddr == FPWDL_DBGACC_OFS);
  assign hit_wstate  = (paddr == FPWDL_WSTATE_OFS);
  assign hit_direct  = (paddr == FPWDL_DIRECT_OFS);
  assign mapped      = hit_ctl | hit_key | hit_payload | hit_unlock
                     | hit_dbgacc | hit_wstate | hit_direct;

  // direct write holds the access phase until the array finishes
  assign direct_hold = pwrite & hit_direct & ~(st.direct_run & prog_done);
  assign pready      = ~direct_hold; // see RULE_11

  // register writes take effect at the completing access edge only; a direct write starts at the first access edge that finds the engine free
  assign wr_access = access & pwrite & pready;

  assign data_lane  = pstrb[0] | pstrb[1];
  assign lock_write = wr_access & hit_unlock;
  // both the debug access and wait-state registers accept the blow pattern
  assign blow_write = wr_access & (hit_dbgacc | hit_wstate);
  assign blow_match = (pwdata[FPWDL_DATA_W-1:0] == FPWDL_BLOW_PATTERN);
  assign other_write = wr_access & ~hit_unlock & ~hit_dbgacc & ~hit_wstate;

  always_comb begin
    next_st        = st;
    prog_start     = 1'b0;
    prog_cmd.addr  = {st.page, st.hw, 1'b0}; // see RULE_10
    prog_cmd.data  = st.data;                // see RULE_09
    if (setup) begin
      next_st.slverr = ~mapped;
      next_st.rdata  = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_ctl) begin
          next_st.rdata[FPWDL_CTL_BUSY_BIT]  = prog_busy; // see RULE_04
          next_st.rdata[FPWDL_CTL_FUSE_BIT]  = fuse_blocked;
          next_st.rdata[FPWDL_CTL_ARMED_BIT] = st.key_ok;
        end else if (hit_payload) begin
          next_st.rdata[FPWDL_DATA_LSB +: FPWDL_DATA_W] = st.data;
          next_st.rdata[FPWDL_HW_LSB +: FPWDL_HW_W]     = st.hw;
          next_st.rdata[FPWDL_PAGE_LSB +: FPWDL_PAGE_W] = st.page;
        end else if (hit_wstate) begin
          next_st.rdata[FPWDL_WS_W-1:0] = st.wstate;
        end
      end
    end
    if (wr_access && hit_key) begin
      next_st.key_ok = (pwdata == FPWDL_UNLOCK_KEY);
    end
    if (wr_access && hit_wstate && !blow_match) begin
      next_st.wstate = pwdata[FPWDL_WS_W-1:0];
    end
    if (wr_access && hit_payload) begin
      if (pstrb[3] || pstrb[2]) begin
        next_st.hw = pwdata[FPWDL_HW_LSB +: FPWDL_HW_W];
      end
      if (pstrb[3]) begin
        next_st.page = pwdata[FPWDL_PAGE_LSB +: FPWDL_PAGE_W];
      end
      if (data_lane) begin
        next_st.data = pwdata[FPWDL_DATA_LSB +: FPWDL_DATA_W];
        // data lane posts; bus completes at once, no key means no post
        if (st.key_ok && !prog_busy) begin // see RULE_08
          prog_start    = 1'b1;              // see RULE_03
          prog_cmd.data = pwdata[FPWDL_DATA_LSB +: FPWDL_DATA_W];
          if (pstrb[3] || pstrb[2]) begin
            prog_cmd.addr = {next_st.page,
                             pwdata[FPWDL_HW_LSB +: FPWDL_HW_W], 1'b0};
          end
        end
        next_st.key_ok = 1'b0;
      end
    end
    // direct write: start once the engine is free, finish on its done pulse
    if (access && pwrite && hit_direct) begin
      if (!st.direct_run && !prog_busy) begin
        prog_start         = 1'b1;
        prog_cmd.data      = pwdata[FPWDL_DATA_LSB +: FPWDL_DATA_W];
        prog_cmd.addr      = {pwdata[FPWDL_PAGE_LSB +: FPWDL_PAGE_W],
                              pwdata[FPWDL_HW_LSB +: FPWDL_HW_W], 1'b0};
        next_st.direct_run = 1'b1;
      end else if (st.direct_run && prog_done) begin
        next_st.direct_run = 1'b0; // see RULE_11
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.wstate <= FPWDL_WSTATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  fpwdl_prog u_prog (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (prog_start),
    .cmd       (prog_cmd),
    .busy      (prog_busy),
    .done      (prog_done),
    .flash_req (flash_req),
    .flash_cmd (flash_cmd),
    .flash_ack (flash_ack)
  );

  fpwdl_fuse u_fuse (
    .pclk        (pclk),
    .presetn     (presetn),
    .lock_write  (lock_write),
    .lock_match  (pwdata == FPWDL_LOCK_PATTERN),
    .blow_write  (blow_write),
    .blow_match  (blow_match),
    .other_write (other_write),
    .fuse_sense  (fuse_sense),
    .fuse_blow   (fuse_blow),
    .dbg_req     (dbg_req),
    .dbg_grant   (dbg_grant),
    .dbg_refused (dbg_refused),
    .blocked     (fuse_blocked),
    .armed       ()
  );

  assign prdata            = st.rdata;
  assign pslverr           = st.slverr & access;
  assign flash_wait_states = st.wstate;
  assign dbg_locked        = fuse_blocked;

endmodule : fpwdl_top

// ### verification/fpwdl_far_model.sv
`timescale 1ns/1ps
module fpwdl_far_model (
  // clock
  input  wire logic       pclk,
  // flash array
  input  wire logic       flash_req,
  input  wire logic [3:0] ack_dly,
  output logic            flash_ack,
  // fuse cell
  input  wire logic       fuse_blow,
  output logic            fuse_sense
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    flash_ack = 1'b0;
    fuse_sense = 1'b0;
  end
  // programming takes ack_dly+1 cycles, acked by a single pulse
  always @(posedge pclk) begin
    flash_ack <= 1'b0;
    if (!flash_req || flash_ack) cnt <= 4'h0;
    else if (cnt == ack_dly) flash_ack <= 1'b1;
    else cnt <= cnt + 4'h1;
  end
  // nonvolatile: no reset reaches the cell
  always @(posedge pclk) begin
    if (fuse_blow) fuse_sense <= 1'b1;
  end
endmodule : fpwdl_far_model

// ### verification/fpwdl_top_chk.sv
`timescale 1ns/1ps
module fpwdl_top_chk
  import fpwdl_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // flash and debug gate
  input wire logic        flash_req,
  input wire fpwdl_cmd_s  flash_cmd,
  input wire logic        flash_ack,
  input wire logic        fuse_blow,
  input wire logic        dbg_req,
  input wire logic        dbg_grant,
  input wire logic        dbg_refused,
  input wire logic        dbg_locked
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic blow_wr;
  assign blow_wr = psel && penable && pready && pwrite
    && pwdata[15:0] == FPWDL_BLOW_PATTERN;
  sequence s_dir_setup;
    psel && !penable && pwrite && paddr == FPWDL_DIRECT_OFS;
  endsequence
  property p_gate;
    dbg_grant == (dbg_req && !dbg_locked)
      && dbg_refused == (dbg_req && dbg_locked);
  endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_stay; dbg_locked |=> dbg_locked; endproperty
  a_stay: assert property (p_stay) else $error("stay");
  property p_blow; fuse_blow |-> dbg_locked ##1 !fuse_blow; endproperty
  a_blow: assert property (p_blow) else $error("blow");
  property p_cause; $rose(fuse_blow) |-> $past(blow_wr); endproperty
  a_cause: assert property (p_cause) else $error("cause");
  property p_nostall;
    psel && penable && paddr != FPWDL_DIRECT_OFS |-> pready;
  endproperty
  a_nostall: assert property (p_nostall) else $error("stl");
  property p_stall; s_dir_setup |=> !pready; endproperty
  a_stall: assert property (p_stall) else $error("dir");
  property p_hold;
    flash_req && !flash_ack |=> flash_req && $stable(flash_cmd);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_end; flash_req && flash_ack |=> !flash_req; endproperty
  a_end: assert property (p_end) else $error("end");
endmodule : fpwdl_top_chk

bind fpwdl_top fpwdl_top_chk chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .flash_req(flash_req),
  .flash_cmd(flash_cmd), .flash_ack(flash_ack), .fuse_blow(fuse_blow),
  .dbg_req(dbg_req), .dbg_grant(dbg_grant), .dbg_refused(dbg_refused),
  .dbg_locked(dbg_locked));

// ### verification/fpwdl_top_tb.sv
`timescale 1ns/1ps
module fpwdl_top_tb
  import fpwdl_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, dbg_req, er;
  logic        pready, pslverr, flash_req, flash_ack, fuse_sense;
  logic        fuse_blow, dbg_grant, dbg_refused, dbg_locked;
  logic [7:0]  paddr;
  logic [3:0]  pstrb, ack_dly;
  logic [1:0]  flash_wait_states;
  logic [31:0] pwdata, prdata, rd, w;
  logic [31:0] seed = 32'hB1041B8D;
  fpwdl_cmd_s  flash_cmd, got_cmd;
  int          fail_count = 0;
  int          n_checks = 0;
  fpwdl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_req(flash_req), .flash_cmd(flash_cmd), .flash_ack(flash_ack),
    .flash_wait_states(flash_wait_states), .fuse_sense(fuse_sense),
    .fuse_blow(fuse_blow), .dbg_req(dbg_req), .dbg_grant(dbg_grant),
    .dbg_refused(dbg_refused), .dbg_locked(dbg_locked));
  fpwdl_far_model far_u (.pclk(pclk), .flash_req(flash_req),
    .ack_dly(ack_dly), .flash_ack(flash_ack), .fuse_blow(fuse_blow),
    .fuse_sense(fuse_sense));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (flash_req && flash_ack) got_cmd <= flash_cmd;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [30:0] exp_cmd(input logic [31:0] v);
    return {15'(v[29:25]) * 15'h400 + 15'(v[24:16]) * 15'h2, v[15:0]};
  endfunction : exp_cmd
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // pready, read data and error are all taken at the completing edge
    @(posedge pclk);
    while (pready !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) fail_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic post(input logic [31:0] v);
    int k;
    apb(1'b1, FPWDL_KEY_OFS, FPWDL_UNLOCK_KEY, 4'hF);
    apb(1'b1, FPWDL_PAYLOAD_OFS, v, 4'h8);
    apb(1'b1, FPWDL_PAYLOAD_OFS, v, 4'hC);
    apb(1'b1, FPWDL_PAYLOAD_OFS, v, 4'h3);
    apb(1'b0, FPWDL_CTL_OFS, 32'h0, 4'h0);
    chk(32'(rd[0]), 32'h1);
    k = 0;
    while (rd[0] !== 1'b0 && k < 40) begin
      apb(1'b0, FPWDL_CTL_OFS, 32'h0, 4'h0);
      k++;
    end
    chk(32'(rd[0]), 32'h0);
    chk(32'(got_cmd), 32'(exp_cmd(v)));
  endtask : post
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pstrb} = '0;
    pwdata = 32'h0;
    dbg_req = 1'b1;
    ack_dly = 4'h8;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FPWDL_CTL_OFS, 32'h0, 4'h0);
    chk(rd, 32'h0);
    apb(1'b0, FPWDL_WSTATE_OFS, 32'h0, 4'h0);
    chk(rd, 32'(FPWDL_WSTATE_RESET));
    apb(1'b0, 8'h1C, 32'h0, 4'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, FPWDL_PAYLOAD_OFS, 32'h0000BEEF, 4'h3);
    @(negedge pclk);
    chk(32'(flash_req), 32'h0);
    for (int i = 0; i < 8; i++) begin
      w = rnd() >> 2;
      if (i == 0) w = 32'h3FFFFEED;
      if (i == 1) w = 32'h0000FEED;
      ack_dly <= 4'h8 | 4'(rnd());
      post(w);
    end
    w = 32'h3E00A55A;
    apb(1'b1, FPWDL_DIRECT_OFS, w, 4'hF);
    chk(32'(flash_req), 32'h0);
    chk(32'(got_cmd), 32'(exp_cmd(w)));
    apb(1'b1, FPWDL_WSTATE_OFS, 32'h1, 4'hF);
    @(negedge pclk);
    chk(32'(flash_wait_states), 32'h1);
    apb(1'b1, FPWDL_UNLOCK_OFS, 32'h12345678, 4'hF);
    apb(1'b1, FPWDL_DBGACC_OFS, 32'h6969, 4'hF);
    apb(1'b1, FPWDL_UNLOCK_OFS, FPWDL_LOCK_PATTERN, 4'hF);
    apb(1'b1, FPWDL_KEY_OFS, 32'h0, 4'hF);
    apb(1'b1, FPWDL_DBGACC_OFS, 32'h6969, 4'hF);
    @(negedge pclk);
    chk(32'(dbg_locked), 32'h0);
    apb(1'b1, FPWDL_UNLOCK_OFS, FPWDL_LOCK_PATTERN, 4'hF);
    apb(1'b1, FPWDL_DBGACC_OFS, 32'h6969, 4'hF);
    @(negedge pclk);
    chk(32'({dbg_locked, dbg_grant}), 32'h2);
    apb(1'b0, FPWDL_CTL_OFS, 32'h0, 4'h0);
    chk(32'(rd[1]), 32'h1);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, FPWDL_UNLOCK_OFS, 32'h0, 4'hF);
    chk(32'({dbg_locked, dbg_refused}), 32'h3);
    // blow pattern on the wait-state register fires the cell, keeps the value
    apb(1'b1, FPWDL_UNLOCK_OFS, FPWDL_LOCK_PATTERN, 4'hF);
    apb(1'b1, FPWDL_WSTATE_OFS, 32'h6969, 4'hF);
    @(negedge pclk);
    chk(32'({fuse_blow, flash_wait_states}), 32'h7);
    report_and_stop();
  end
endmodule : fpwdl_top_tb
